// file: verilog/lss_pkg.sv
// Shared constants for the linear sensor scan timing ends
package lss_pkg;
  // Array geometry
  localparam int unsigned VIDEO_W          = 12;
  localparam int unsigned CNT_W            = 16;
  localparam logic [11:0] PIXELS_FULL      = 12'h0800;   // 2048 channels
  localparam logic [11:0] PIXELS_HALF      = 12'h0400;   // 1024 channels
  localparam logic [11:0] HALF_CH_OFFSET   = 12'h0200;   // Channel 513 is first in half mode
  // Scan sequence counts, in pixel clock periods
  localparam logic [11:0] FIRST_VALID_STB  = 12'h0059;   // 89th strobe carries channel 1
  localparam logic [11:0] INTEG_EXTRA      = 12'h0030;   // 48 clocks after start falls
  localparam logic [15:0] START_HIGH_MIN   = 16'h0006;   // 6 clocks
  localparam logic [15:0] START_LOW_MIN    = 16'h005C;   // 92 clocks
  localparam logic [15:0] START_PERIOD_MIN = 16'h0062;   // 98 clocks
  localparam logic [15:0] PERIOD_FULL      = 16'h085C;   // 2140 clocks
  localparam logic [15:0] PERIOD_HALF      = 16'h045C;   // 1116 clocks
  // Clock rates and the pixel clock divider derived from them
  localparam int unsigned CORE_CLK_HZ      = 20_000_000;
  localparam int unsigned PIX_CLK_MAX_HZ   = 10_000_000;
  localparam int unsigned PIX_DIV          = (CORE_CLK_HZ + PIX_CLK_MAX_HZ - 1) / PIX_CLK_MAX_HZ;
  localparam logic [3:0]  PIX_HALF_CYC     = 4'(PIX_DIV / 2);
endpackage : lss_pkg

// file: verilog/lss_link_if.sv
// Pin-level link between the sensor timing end and the external controller
`timescale 1ns/1ps
interface lss_link_if;
  logic                       pix_clk;
  logic                       scan_start_pulse;
  logic                       half_array_select;
  logic [lss_pkg::VIDEO_W-1:0] video;
  logic                       sample_strobe;

  modport sensor (
    input  pix_clk,
    input  scan_start_pulse,
    input  half_array_select,
    output video,
    output sample_strobe
  );

  modport ctrl (
    output pix_clk,
    output scan_start_pulse,
    output half_array_select,
    input  video,
    input  sample_strobe
  );
endinterface : lss_link_if

// file: verilog/lss_sensor.sv
// Sensor end: built-in timing generator driven only by start pulse and pixel clock
// Overview of operation
// - All pixels integrate in one shared window
// - Only start pulse and pixel clock run scans
// - Full mode shifts out all 2048 channels
// - Controller keeps pixel clock at most 10 MHz
// - Start rising edges at least 98 clocks apart
// - Start held high at least 6 clocks
// - Start held low at least 92 clocks
// - Integration equals high period plus 48 clocks
// - Controller sets integration by high/low split
// - Shifting begins first pixel rise after fall
// - Controller samples video on strobe rising edge
// - Strobes counted from one; 89th is first
// - Half select high reads channels 513 to 1536
// - Sample strobe is a sensor output
// - Full mode shortest period is 2140 clocks
// - Half mode shortest period is 1116 clocks
`timescale 1ns/1ps
module lss_sensor (
  input  wire logic             CORE_CLK,
  input  wire logic             RESET_N,
  lss_link_if.sensor            LINK,
  output      logic             INTEGRATING,
  output      logic             SCAN_ACTIVE
);

  typedef enum logic [2:0] {
    SN_IDLE  = 3'b001,
    SN_INTEG = 3'b010,
    SN_SHIFT = 3'b100
  } lss_sns_e;

  typedef struct packed {
    lss_sns_e                    state;
    logic                        pix_prev;
    logic                        start_prev;
    logic                        half;
    logic [11:0]                 cnt;
    logic                        strobe;
    logic                        integ;
    logic [lss_pkg::VIDEO_W-1:0] video;
  } lss_sns_s;

  lss_sns_s s_ff;
  lss_sns_s nxt_s;

  logic        pix_rise;
  logic        pix_fall;
  logic [11:0] last_cnt;
  logic [11:0] new_cnt;

  // Edge detection of the pixel clock; inputs are synchronous to the core clock
  assign pix_rise = LINK.pix_clk & ~s_ff.pix_prev;
  assign pix_fall = ~LINK.pix_clk & s_ff.pix_prev;
  assign new_cnt  = s_ff.cnt + 12'h0001;
  // Strobe number of the final pixel, depending on array size
  assign last_cnt = lss_pkg::FIRST_VALID_STB - 12'h0001 +
                    (s_ff.half ? lss_pkg::PIXELS_HALF : lss_pkg::PIXELS_FULL);

  // Next-state logic of the whole timing generator
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.pix_prev = LINK.pix_clk;
    if (pix_fall) begin
      nxt_s.strobe = 1'b0;                                  // Strobe lasts one core cycle
    end
    if (pix_rise) begin
      nxt_s.start_prev = LINK.scan_start_pulse;
      if (LINK.scan_start_pulse && !s_ff.start_prev) begin
        // Start rising edge opens the shared window for every pixel
        nxt_s.state  = SN_INTEG;
        nxt_s.integ  = 1'b1;
        nxt_s.strobe = 1'b0;
        nxt_s.video  = '0;
        nxt_s.cnt    = '0;
      end else begin
        unique case (s_ff.state)
          SN_IDLE: begin
            nxt_s.video = '0;
          end
          SN_INTEG: begin
            if (!LINK.scan_start_pulse) begin
              nxt_s.state  = SN_SHIFT;
              nxt_s.cnt    = 12'h0001;                      // First strobe is number one
              nxt_s.strobe = 1'b1;
              nxt_s.half   = LINK.half_array_select;        // Held for the scan
            end
          end
          SN_SHIFT: begin
            if (s_ff.cnt == last_cnt) begin
              nxt_s.state = SN_IDLE;
              nxt_s.video = '0;
            end else begin
              nxt_s.cnt    = new_cnt;
              nxt_s.strobe = 1'b1;                          // One strobe per pixel clock
              if (new_cnt >= lss_pkg::FIRST_VALID_STB) begin
                // Channel number stands in for the analog level
                nxt_s.video = new_cnt - lss_pkg::FIRST_VALID_STB + 12'h0001 +
                              (s_ff.half ? lss_pkg::HALF_CH_OFFSET : 12'h0000);
              end else begin
                nxt_s.video = '0;
              end
            end
          end
        endcase
        // Window closes 48 clocks after the start pulse falls
        if (s_ff.state == SN_SHIFT && new_cnt == lss_pkg::INTEG_EXTRA) begin
          nxt_s.integ = 1'b0;
        end
      end
    end
    if (!RESET_N) begin
      nxt_s       = '0;
      nxt_s.state = SN_IDLE;
    end
  end

  // Single state register
  always_ff @(posedge CORE_CLK) begin
    s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign LINK.video         = s_ff.video;
  assign LINK.sample_strobe = s_ff.strobe;
  assign INTEGRATING        = s_ff.integ;
  assign SCAN_ACTIVE        = s_ff.state[2];

endmodule : lss_sensor

// file: verilog/lss_ctrl.sv
// Controller end: makes pixel clock and start pulse, captures video on each strobe from the 89th to the last
`timescale 1ns/1ps
module lss_ctrl (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET_N,
  lss_link_if.ctrl                         LINK,
  input  wire logic                        START,
  input  wire logic [lss_pkg::CNT_W-1:0]   HIGH_CYCLES,
  input  wire logic                        HALF_SEL,
  output      logic [lss_pkg::VIDEO_W-1:0] PIX_DATA,
  output      logic                        PIX_VALID,
  output      logic                        SCAN_DONE,
  output      logic                        BUSY
);

  typedef enum logic [3:0] {
    CT_IDLE = 4'b0001,
    CT_ARM  = 4'b0010,
    CT_HIGH = 4'b0100,
    CT_LOW  = 4'b1000
  } lss_ctl_e;

  typedef struct packed {
    lss_ctl_e                    state;
    logic [3:0]                  div;
    logic                        pix;
    logic                        start_lvl;
    logic                        half;
    logic [15:0]                 high_len;
    logic [15:0]                 low_need;
    logic [15:0]                 cnt;
    logic                        stb_prev;
    logic [11:0]                 stb_num;
    logic [lss_pkg::VIDEO_W-1:0] data;
    logic                        valid;
    logic                        done;
    logic                        busy;
  } lss_ctl_s;

  lss_ctl_s s_ff;
  lss_ctl_s nxt_s;

  logic        toggle;
  logic        rise_evt;
  logic        fall_evt;
  logic        stb_rise;
  logic [11:0] stb_new;
  logic [11:0] stb_last;
  logic [15:0] hl_req;
  logic [15:0] period_min;

  // Pixel clock divider events; start changes only on falling edges
  assign toggle     = (s_ff.div == lss_pkg::PIX_HALF_CYC - 4'h1);
  assign rise_evt   = toggle & ~s_ff.pix;
  assign fall_evt   = toggle & s_ff.pix;
  assign stb_rise   = LINK.sample_strobe & ~s_ff.stb_prev;
  assign stb_new    = s_ff.stb_num + 12'h0001;
  assign stb_last   = lss_pkg::FIRST_VALID_STB - 12'h0001 +
                      (s_ff.half ? lss_pkg::PIXELS_HALF : lss_pkg::PIXELS_FULL);
  // High period never below the least width
  assign hl_req     = (HIGH_CYCLES < lss_pkg::START_HIGH_MIN) ? lss_pkg::START_HIGH_MIN : HIGH_CYCLES;
  // Shortest scan period; it also covers the 98-clock spacing
  assign period_min = HALF_SEL ? lss_pkg::PERIOD_HALF : lss_pkg::PERIOD_FULL;

  // Next-state logic of the controller
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.valid    = 1'b0;
    nxt_s.done     = 1'b0;
    nxt_s.stb_prev = LINK.sample_strobe;
    nxt_s.div      = toggle ? 4'h0 : s_ff.div + 4'h1;
    if (toggle) begin
      nxt_s.pix = ~s_ff.pix;
    end
    // Strobe rising edges are counted from one; video is taken from the 89th to the last
    if (stb_rise) begin
      nxt_s.stb_num = stb_new;
      if (stb_new >= lss_pkg::FIRST_VALID_STB && stb_new <= stb_last) begin
        nxt_s.data  = LINK.video;
        nxt_s.valid = 1'b1;
      end
    end
    unique case (s_ff.state)
      CT_IDLE: begin
        if (START) begin
          nxt_s.state    = CT_ARM;
          nxt_s.busy     = 1'b1;
          nxt_s.half     = HALF_SEL;
          nxt_s.high_len = hl_req;
          // Low part fills the period but never under 92 clocks
          nxt_s.low_need = (hl_req < period_min - lss_pkg::START_LOW_MIN) ?
                           period_min - hl_req : lss_pkg::START_LOW_MIN;
        end
      end
      CT_ARM: begin
        if (fall_evt) begin
          nxt_s.state   = CT_HIGH;
          nxt_s.start_lvl = 1'b1;
          nxt_s.cnt     = '0;
          nxt_s.stb_num = '0;
        end
      end
      CT_HIGH: begin
        if (rise_evt) begin
          nxt_s.cnt = s_ff.cnt + 16'h0001;
        end
        if (fall_evt && s_ff.cnt >= s_ff.high_len) begin
          nxt_s.state = CT_LOW;
          nxt_s.start_lvl = 1'b0;
          nxt_s.cnt   = '0;
        end
      end
      CT_LOW: begin
        if (rise_evt && s_ff.cnt != 16'hFFFF) begin
          nxt_s.cnt = s_ff.cnt + 16'h0001;
        end
        if (fall_evt && s_ff.cnt >= s_ff.low_need && s_ff.stb_num >= stb_last) begin
          nxt_s.state = CT_IDLE;
          nxt_s.done  = 1'b1;
          nxt_s.busy  = 1'b0;
        end
      end
    endcase
    if (!RESET_N) begin
      nxt_s       = '0;
      nxt_s.state = CT_IDLE;
    end
  end

  // Single state register
  always_ff @(posedge CORE_CLK) begin
    s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign LINK.pix_clk           = s_ff.pix;
  assign LINK.scan_start_pulse  = s_ff.start_lvl;
  assign LINK.half_array_select = s_ff.half;
  assign PIX_DATA               = s_ff.data;
  assign PIX_VALID              = s_ff.valid;
  assign SCAN_DONE              = s_ff.done;
  assign BUSY                   = s_ff.busy;

endmodule : lss_ctrl

// file: testbench/lss_link_checker.sv
// Concurrent checks on the link between sensor and controller ends
`timescale 1ns/1ps
module lss_link_checker (
  input wire logic                        CORE_CLK,
  input wire logic                        RESET_N,
  input wire logic                        pix_clk,
  input wire logic                        scan_start_pulse,
  input wire logic                        half_array_select,
  input wire logic [lss_pkg::VIDEO_W-1:0] video,
  input wire logic                        sample_strobe,
  input wire logic                        INTEGRATING
);
  logic [15:0] hi_cnt_ff;
  logic [15:0] lo_cnt_ff;
  logic [15:0] per_cnt_ff;
  logic [11:0] stb_n_ff;
  logic        per_half_ff;
  logic [11:0] offs;
  logic [11:0] n_px;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // Channel offset and pixel count of the current mode
  assign offs = half_array_select ? lss_pkg::HALF_CH_OFFSET : 12'h000;
  assign n_px = half_array_select ? lss_pkg::PIXELS_HALF : lss_pkg::PIXELS_FULL;

  // Start high, start low and start period in core cycles; strobes since start fell
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      hi_cnt_ff  <= 16'h0000;
      lo_cnt_ff  <= 16'hFFFF; // Saturated so the first rise after reset passes
      per_cnt_ff <= 16'hFFFF;
      stb_n_ff   <= 12'h000;
      per_half_ff <= 1'b0;
    end else begin
      // Mode of the scan that the current start period belongs to
      per_half_ff <= $rose(scan_start_pulse) ? half_array_select : per_half_ff;
      hi_cnt_ff  <= scan_start_pulse ? hi_cnt_ff + 16'h0001 : 16'h0000;
      lo_cnt_ff  <= scan_start_pulse ? 16'h0000 : ((lo_cnt_ff == 16'hFFFF) ? lo_cnt_ff : lo_cnt_ff + 16'h0001);
      per_cnt_ff <= $rose(scan_start_pulse) ? 16'h0001 :
                    ((per_cnt_ff == 16'hFFFF) ? per_cnt_ff : per_cnt_ff + 16'h0001);
      stb_n_ff   <= scan_start_pulse ? 12'h000 : (sample_strobe ? stb_n_ff + 12'h001 : stb_n_ff);
    end
  end

  a_pix_rate_max:
    assert property (pix_clk |=> !pix_clk) else $error("pixel clock high two core cycles running");
  a_start_high_min:
    assert property ($fell(scan_start_pulse) |-> hi_cnt_ff >= 16'h000C) else $error("start high too short");
  a_start_low_min:
    assert property ($rose(scan_start_pulse) |-> lo_cnt_ff >= 16'h00B8) else $error("start low too short");
  a_start_period_min:
    assert property ($rose(scan_start_pulse) |-> per_cnt_ff >= {lss_pkg::START_PERIOD_MIN[14:0], 1'b0})
      else $error("start period too short");
  a_period_recommended:
    assert property ($rose(scan_start_pulse) |-> per_cnt_ff >= (per_half_ff ? 16'h08B8 : 16'h10B8))
      else $error("start period below shortest scan length");
  a_shift_begins:
    assert property ($fell(scan_start_pulse) |-> ##[0:3] sample_strobe) else $error("no strobe after start fell");
  a_strobe_per_pixel:
    assert property (sample_strobe && (stb_n_ff < n_px + 12'h057) |=> !sample_strobe ##1 sample_strobe)
      else $error("strobe spacing wrong while shifting");
  a_video_leadin:
    assert property (sample_strobe && (stb_n_ff < 12'h058) |-> video == 12'h000)
      else $error("video nonzero before first valid strobe");
  a_video_channel:
    assert property (sample_strobe && (stb_n_ff >= 12'h058) && (stb_n_ff < n_px + 12'h058)
      |-> video == stb_n_ff - 12'h057 + offs) else $error("video channel wrong");
  a_integ_end:
    assert property ($fell(INTEGRATING) |-> sample_strobe && (stb_n_ff == 12'h02F))
      else $error("integration did not end at strobe 48");
  a_integ_start:
    assert property ($rose(INTEGRATING) |-> scan_start_pulse) else $error("integration began without start");
  a_half_steady:
    assert property (sample_strobe |-> $stable(half_array_select)) else $error("half select moved in scan");
endmodule : lss_link_checker

// file: testbench/linear_sensor_scan_timing_tb.sv
// Self-checking bench joining the sensor end and the controller end
`timescale 1ns/1ps
module linear_sensor_scan_timing_tb;
  logic                        core_clk;
  logic                        reset_n;
  logic                        start;
  logic [lss_pkg::CNT_W-1:0]   high_cycles;
  logic                        half_sel;
  logic [lss_pkg::VIDEO_W-1:0] pix_data;
  logic                        pix_valid;
  logic                        scan_done;
  logic                        busy;
  logic                        integrating;
  logic                        scan_active;
  int                          n_mismatch;
  int                          checked;

  lss_link_if lss_link_if_i ();
  lss_sensor lss_sensor_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(lss_link_if_i.sensor),
    .INTEGRATING(integrating), .SCAN_ACTIVE(scan_active));
  lss_ctrl lss_ctrl_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(lss_link_if_i.ctrl), .START(start),
    .HIGH_CYCLES(high_cycles), .HALF_SEL(half_sel), .PIX_DATA(pix_data), .PIX_VALID(pix_valid),
    .SCAN_DONE(scan_done), .BUSY(busy));
  lss_link_checker lss_link_checker_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .pix_clk(lss_link_if_i.pix_clk),
    .scan_start_pulse(lss_link_if_i.scan_start_pulse), .half_array_select(lss_link_if_i.half_array_select),
    .video(lss_link_if_i.video), .sample_strobe(lss_link_if_i.sample_strobe), .INTEGRATING(integrating));

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Print the verdict and stop
  task automatic results;
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // One scan: checks channel order and count, pokes START while busy, returns integration length
  task automatic run_scan(input logic hs, input logic [15:0] hc, input logic [11:0] first,
                          input logic [15:0] n_exp, output int integ);
    logic [11:0] exp_d;
    int          cnt;
    int          act;
    int          i;
    exp_d = first;
    cnt = 0;
    act = 0;
    integ = 0;
    @(negedge core_clk);
    half_sel = hs;
    high_cycles = hc;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (i = 0; i < 10000 && scan_done !== 1'b1; i++) begin
      @(negedge core_clk);
      start = (i == 600); // Must be ignored while busy
      if (pix_valid === 1'b1) begin
        check({4'h0, pix_data}, {4'h0, exp_d});
        exp_d = exp_d + 12'h001;
        cnt++;
      end
      if (integrating === 1'b1)
        integ++;
      if (scan_active === 1'b1)
        act++;
    end
    check(16'(cnt), n_exp);
    check(16'(act), 16'((n_exp + 16'(lss_pkg::FIRST_VALID_STB) - 16'h0001) * 16'h0002));
    repeat (4) @(negedge core_clk);
    check({15'h0000, busy}, 16'h0000);
  endtask : run_scan

  // Full array at the shortest start high
  task automatic t_full_scan;
    int ia;
    run_scan(1'b0, 16'h0006, 12'h001, {4'h0, lss_pkg::PIXELS_FULL}, ia);
    check(16'(ia >= 106 && ia <= 110), 16'h0001);
  endtask : t_full_scan

  // Half array, back to back, three start high lengths, the first below the minimum
  task automatic t_half_integration;
    int ia;
    int ib;
    int ic;
    run_scan(1'b1, 16'h0003, lss_pkg::HALF_CH_OFFSET + 12'h001, {4'h0, lss_pkg::PIXELS_HALF}, ia);
    run_scan(1'b1, 16'h0014, lss_pkg::HALF_CH_OFFSET + 12'h001, {4'h0, lss_pkg::PIXELS_HALF}, ib);
    run_scan(1'b1, 16'h0028, lss_pkg::HALF_CH_OFFSET + 12'h001, {4'h0, lss_pkg::PIXELS_HALF}, ic);
    check(16'(ib - ia), 16'h001C);
    check(16'(ic - ib), 16'h0028);
  endtask : t_half_integration

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Reset then the scenarios
  initial begin
    reset_n = 1'b0;
    start = 1'b0;
    high_cycles = 16'h0006;
    half_sel = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    t_full_scan;
    t_half_integration;
    results;
  end

  // Watchdog well beyond the four scans
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    results;
  end
endmodule : linear_sensor_scan_timing_tb
